// File: common/stcu_pkg.sv
/*
 * Shared constants and types of the static memory timing configuration block:
 * register offsets, field positions, command codes, state encoding and carriers.
 * Assumes one 100 MHz clock and a byte-addressed plain register port.
 */
package stcu_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_APPLY_COMMAND = 8'h00;
    localparam logic [7:0] OFS_CYCLE_STAGING = 8'h04;
    localparam logic [7:0] OFS_MODE_STAGING = 8'h08;
    localparam logic [7:0] OFS_OPERATION_MODE = 8'h0c;
    localparam logic [7:0] OFS_TIMING_SHADOW0 = 8'h10;
    localparam logic [7:0] OFS_MODE_SHADOW0 = 8'h20;
    localparam logic [7:0] OFS_BUS_CONTROL = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;
    localparam logic [7:0] OFS_AREA_STEP = 8'h04;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned CMD_AREA_MSB = 25;
    localparam int unsigned CMD_AREA_LSB = 23;
    localparam int unsigned CMD_TYPE_MSB = 22;
    localparam int unsigned CMD_TYPE_LSB = 21;
    localparam logic [1:0] CMD_TYPE_UPDATE = 2'h2;
    localparam int unsigned TIM_W = 21;
    localparam int unsigned TIM_WE_TIME_BIT = 20;
    localparam int unsigned TIM_TR_MSB = 19;
    localparam int unsigned TIM_TR_LSB = 17;
    localparam int unsigned TIM_PC_MSB = 16;
    localparam int unsigned TIM_PC_LSB = 14;
    localparam int unsigned TIM_WP_MSB = 13;
    localparam int unsigned TIM_WP_LSB = 11;
    localparam int unsigned TIM_CEOE_MSB = 10;
    localparam int unsigned TIM_CEOE_LSB = 8;
    localparam int unsigned TIM_WC_MSB = 7;
    localparam int unsigned TIM_WC_LSB = 4;
    localparam int unsigned TIM_RC_MSB = 3;
    localparam int unsigned TIM_RC_LSB = 0;
    localparam int unsigned MODE_W = 16;
    localparam int unsigned MODE_BURST_MSB = 15;
    localparam int unsigned MODE_BURST_LSB = 13;
    localparam int unsigned MODE_WR_SYNC_BIT = 6;
    localparam int unsigned OPM_W = 5;
    localparam int unsigned OPM_WRITE_HOLD_BIT = 1;
    localparam int unsigned CTL_MUX_BIT = 0;
    localparam logic [4:0] WE_LATE_CYCLES = 5'h02;
    localparam int unsigned AREAS = 4;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0]
    {
        SM_IDLE = 3'h1,
        SM_TURN = 3'h2,
        SM_ACCESS = 3'h4
    } stcu_state_e;

    typedef struct packed
    {
        logic write;
        logic [1:0] area;
    } stcu_req_s;

    typedef struct packed
    {
        logic [AREAS-1:0] area_select_n;
        logic read_strobe_n;
        logic write_strobe_n;
    } stcu_pins_s;

    typedef struct packed
    {
        stcu_state_e state;
        logic [31:0] rdata;
        logic [4:0] cmd;
        logic [TIM_W-1:0] cyc_stage;
        logic [MODE_W-1:0] mode_stage;
        logic [OPM_W-1:0] opmode;
        logic mux;
        logic [AREAS-1:0][TIM_W-1:0] tim_sh;
        logic [AREAS-1:0][MODE_W-1:0] mode_sh;
        logic [3:0] cnt;
        logic [1:0] area;
        logic wr;
        logic wr_sync;
        logic [TIM_W-1:0] tim;
        logic [8:0] boundary;
        logic have_last;
        logic last_wr;
        logic [1:0] last_area;
        logic cs;
        logic rs;
        logic ws;
        logic done;
    } stcu_state_s;

endpackage

// File: dv/sram_timing_config_update_bench.sv
/*
 * Self-checking bench of the timing configuration block: register staging and
 * apply command, shadow readback, and single accesses against the memory model.
 * Assumes the design answers reads one cycle after the strobe and idles after reset.
 */
`define CHK(act, exp) \
    begin \
        n_compared++; \
        if ((act) !== (exp)) \
        begin \
            miscompares++; \
            $display("ERROR at %0t: got %0h, expected %0h", $time, (act), (exp)); \
        end \
    end

module sram_timing_config_update_bench import stcu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk_i;
    logic reset_n_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic reg_we_i;
    logic reg_re_i;
    logic [31:0] reg_rdata_o;
    logic req_valid_i;
    stcu_req_s req_i;
    logic req_ready_o;
    logic mem_wait_i;
    stcu_pins_s pins_o;
    logic access_done_o;
    logic [8:0] burst_boundary_o;
    logic [3:0] wait_len;
    logic [3:0] sel;
    logic [4:0] cs_len;
    logic [4:0] rs_at;
    logic [4:0] ws_at;
    logic [4:0] ws_len;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    stcu_top u_dut
    (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o),
        .req_valid_i(req_valid_i),
        .req_i(req_i),
        .req_ready_o(req_ready_o),
        .mem_wait_i(mem_wait_i),
        .pins_o(pins_o),
        .access_done_o(access_done_o),
        .burst_boundary_o(burst_boundary_o)
    );

    stcu_sram_model u_sram
    (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .pins_i(pins_o),
        .wait_len_i(wait_len),
        .mem_wait_o(mem_wait_i),
        .sel_o(sel),
        .cs_len_o(cs_len),
        .rs_at_o(rs_at),
        .ws_at_o(ws_at),
        .ws_len_o(ws_len)
    );

    always #5 ref_clk_i = ~ref_clk_i;

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Whole run needs a few hundred cycles; the ceiling leaves ample margin
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_re_i <= 1'b0;
        @(negedge ref_clk_i);
        `CHK(reg_rdata_o, exp)
    endtask

    // Gap is counted in cycles from the accepting edge to the first select cycle
    task automatic access(input logic wr_a, input logic [1:0] ar, input logic [3:0] wl, input int exp_gap);
        int gap;
        int n;
        @(posedge ref_clk_i);
        req_i <= '{write: wr_a, area: ar};
        req_valid_i <= 1'b1;
        wait_len <= wl;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        gap = 1;
        @(negedge ref_clk_i);
        while ((&pins_o.area_select_n) && gap < 40)
        begin
            @(negedge ref_clk_i);
            gap++;
        end
        `CHK(req_ready_o, 1'b0)
        n = 0;
        while (access_done_o !== 1'b1 && n < 60)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        `CHK(gap, exp_gap)
        `CHK(access_done_o, 1'b1)
        `CHK(req_ready_o, 1'b1)
        `CHK(sel, 4'h1 << ar)
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic apply_scenario();
        reg_read(8'h3c, 32'h0);
        // Both staging registers are written before the first two apply commands; the later ones reuse the staged values
        reg_write(OFS_CYCLE_STAGING, 32'h0006_5153);
        reg_write(OFS_MODE_STAGING, 32'h0000_4000);
        reg_write(OFS_APPLY_COMMAND, 32'h0140_0000);
        reg_read(OFS_TIMING_SHADOW0 + 8'h08, 32'h0006_5153);
        reg_read(OFS_MODE_SHADOW0 + 8'h08, 32'h0000_4000);
        reg_read(OFS_APPLY_COMMAND, 32'h0140_0000);
        reg_read(OFS_TIMING_SHADOW0, 32'h0);
        reg_write(OFS_CYCLE_STAGING, 32'h0014_5a46);
        reg_write(OFS_MODE_STAGING, 32'h0);
        reg_write(OFS_APPLY_COMMAND, 32'h0120_0000);
        reg_read(OFS_TIMING_SHADOW0 + 8'h08, 32'h0006_5153);
        reg_write(OFS_APPLY_COMMAND, 32'h0240_0000);
        reg_read(OFS_TIMING_SHADOW0, 32'h0);
        reg_write(OFS_APPLY_COMMAND, 32'h0040_0000);
        reg_write(OFS_APPLY_COMMAND, 32'h00c0_0000);
        reg_read(OFS_TIMING_SHADOW0 + 8'h04, 32'h0014_5a46);
    endtask

    task automatic separate_scenario();
        access(1'b0, 2'h2, 4'h0, 1);
        `CHK(cs_len, 5'h03)
        `CHK(rs_at, 5'h01)
        `CHK(burst_boundary_o, 9'h040)
        access(1'b0, 2'h2, 4'h2, 1);
        `CHK(cs_len, 5'h05)
        access(1'b1, 2'h2, 4'h0, 4);
        `CHK(cs_len, 5'h05)
        `CHK(ws_len, 5'h02)
        access(1'b0, 2'h0, 4'h0, 3);
        `CHK(rs_at, 5'h02)
        `CHK(cs_len, 5'h06)
        access(1'b0, 2'h1, 4'h0, 3);
        reg_write(OFS_OPERATION_MODE, 32'h2);
        access(1'b1, 2'h2, 4'h0, 4);
        `CHK(ws_len, 5'h05)
        reg_write(OFS_OPERATION_MODE, 32'h0);
    endtask

    task automatic mux_scenario();
        // Multiplexed mode: start counts of 4 and 5 and no reads at all
        reg_write(OFS_BUS_CONTROL, 32'h1);
        access(1'b1, 2'h2, 4'h0, 4);
        `CHK(ws_at, 5'h02)
        access(1'b1, 2'h0, 4'h0, 3);
        `CHK(ws_at, 5'h00)
        reg_write(OFS_BUS_CONTROL, 32'h0);
    endtask

    task automatic boundary_scenario();
        for (int code = 0; code < 5; code++)
        begin
            reg_write(OFS_MODE_STAGING, 32'(code) << 13);
            reg_write(OFS_APPLY_COMMAND, 32'h01c0_0000);
            reg_read(OFS_MODE_SHADOW0 + 8'h0c, 32'(code) << 13);
            access(1'b0, 2'h3, 4'h0, (code == 0) ? 3 : 1);
            `CHK(burst_boundary_o, (code == 0) ? 9'h000 : 9'h010 << code)
        end
    endtask

    initial
    begin
        ref_clk_i = 1'b0;
        reset_n_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        reg_we_i = 1'b0;
        reg_re_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '{write: 1'b0, area: 2'h0};
        wait_len = 4'h0;
        repeat (12) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        apply_scenario();
        separate_scenario();
        mux_scenario();
        boundary_scenario();
        results();
    end
endmodule

// File: dv/stcu_sram_model.sv
/*
 * Behavioural model of the external static memory behind the controller pins:
 * measures select and strobe timing of each access and raises wait on request.
 * Assumes the controller clock and active-low selects and strobes.
 */
module stcu_sram_model
    import stcu_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire stcu_pkg::stcu_pins_s pins_i,
    input wire logic [3:0] wait_len_i,
    output logic mem_wait_o,
    output logic [3:0] sel_o,
    output logic [4:0] cs_len_o,
    output logic [4:0] rs_at_o,
    output logic [4:0] ws_at_o,
    output logic [4:0] ws_len_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic cs;
    logic cs_q;
    logic rs_q;
    logic [3:0] wcnt_q;

    assign cs = ~&pins_i.area_select_n;
    // Wait begins in the second select cycle, so there is always a running access to stretch
    assign mem_wait_o = cs && cs_q && (wcnt_q < wait_len_i);

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cs_q <= 1'b0;
            rs_q <= 1'b0;
            wcnt_q <= 4'h0;
            sel_o <= 4'h0;
            cs_len_o <= 5'h00;
            rs_at_o <= 5'h00;
            ws_at_o <= 5'h00;
            ws_len_o <= 5'h00;
        end
        else
        begin
            cs_q <= cs;
            rs_q <= cs && !pins_i.read_strobe_n;
            wcnt_q <= cs ? wcnt_q + 4'(mem_wait_o) : 4'h0;
            if (cs)
            begin
                sel_o <= ~pins_i.area_select_n;
                cs_len_o <= cs_q ? cs_len_o + 5'h01 : 5'h01;
                ws_len_o <= (cs_q ? ws_len_o : 5'h00) + 5'(!pins_i.write_strobe_n);
                // Only the first read strobe cycle of this access is recorded
                if (!pins_i.read_strobe_n && !(cs_q && rs_q))
                    rs_at_o <= cs_q ? cs_len_o : 5'h00;
                if (!pins_i.write_strobe_n && !(cs_q && ws_len_o != 5'h00))
                    ws_at_o <= cs_q ? cs_len_o : 5'h00;
            end
        end
    end
endmodule

// File: hdl/stcu_top.sv
/*
 * Configuration path and single-access sequencer of an external static memory
 * controller: staging registers, apply command, per-area shadow registers, and
 * the chip-select / strobe timing those shadows drive.
 * Assumes synchronous inputs, a plain register port with read data one cycle
 * after the read strobe, and a master that never strobes read and write at once.
 */
// Implementation choices: the strobed register port and the placing of the registers.
// Summary of operation
// RQ1: Apply command write copies both staging registers into the chosen area shadows.
// RQ2: Area selector bits 25..23 pick area 0..3; codes 1xx are never written.
// RQ3: Command type bits 22..21 must be 10, register update; others are not written.
// RQ4: Reserved command bits read zero and are written as zero.
// RQ5: Multiplexed asynchronous writes: bit 20 low delays write strobe two cycles.
// RQ6: Turnaround bits 19..17 give 1..7 gap cycles; zero never programmed.
// RQ7: Gap inserted read to write, write to read, reads to different areas.
// RQ8: Multiplexed bus mode inserts the gap between all consecutive accesses.
// RQ9: Page access bits 16..14 give 1..7 cycles, separate asynchronous reads only.
// RQ10: Write strobe width bits 13..11 hold the strobe 1..7 cycles.
// RQ11: Write-hold option keeps write strobe asserted as long as chip-select.
// RQ12: Bits 10..8 delay read strobe 1..7 cycles after chip-select.
// RQ13: Write start bits 7..4 give 2..15 cycles after chip-select.
// RQ14: Read start bits 3..0 give 2..15 cycles after chip-select.
// RQ15: Single accesses hold chip-select exactly the write or read start count.
// RQ16: Software keeps start counts 0011..1111 in multiplexed mode.
// RQ17: Software keeps read strobe delay in the contention-safe ranges in multiplexed mode.
// RQ18: Memory wait stretches the current access for as long as it lasts.
// RQ19: Burst boundary bits 15..13 encode none, 32, 64, 128, 256 data.
// RQ20: Software programs both staging registers before issuing the update.
// RQ21: Area mode shadows read back the applied mode in the low 16 bits.
// RQ22: Accesses after an update use the newly applied area values.
module stcu_top
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [stcu_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    input wire logic req_valid_i,
    input wire stcu_pkg::stcu_req_s req_i,
    output logic req_ready_o,
    input wire logic mem_wait_i,
    output stcu_pkg::stcu_pins_s pins_o,
    output logic access_done_o,
    output logic [8:0] burst_boundary_o
);
    import stcu_pkg::*;

    stcu_state_s s_q;
    stcu_state_s s_d;
    logic need_turn;
    logic [2:0] tr;
    logic [3:0] len;
    logic [4:0] ws_start;
    logic [4:0] ws_end;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [8:0] boundary_of(input logic [2:0] code);
        logic [8:0] b;
        b = 9'h000;
        unique case (code)
            3'h1: b = 9'h020;
            3'h2: b = 9'h040;
            3'h3: b = 9'h080;
            3'h4: b = 9'h100;
            default: b = 9'h000;
        endcase
        return b;
    endfunction

    function automatic logic [3:0] area_of(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] diff;
        diff = addr - base;
        return {2'h0, diff[3:2]};
    endfunction

    assign tr = s_q.tim[TIM_TR_MSB:TIM_TR_LSB];
    assign len = s_q.wr ? s_q.tim[TIM_WC_MSB:TIM_WC_LSB] : s_q.tim[TIM_RC_MSB:TIM_RC_LSB];
    // Turnaround is counted from acceptance of the next request, so idle time does not shorten it
    assign need_turn = s_q.have_last
        && (s_q.mux // [RQ8]
        || (s_q.last_wr != req_i.write) // [RQ7]
        || (!req_i.write && (s_q.last_area != req_i.area))); // [RQ7]

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.rdata = 32'h0000_0000;
        s_d.done = 1'b0;
        ws_start = 5'h00;
        ws_end = 5'h00;

        if (reg_we_i)
        begin
            case (reg_addr_i)
                OFS_APPLY_COMMAND:
                begin
                    s_d.cmd = reg_wdata_i[CMD_AREA_MSB:CMD_TYPE_LSB];
                    // Prohibited codes are ignored so a stray write cannot corrupt an area
                    if (reg_wdata_i[CMD_TYPE_MSB:CMD_TYPE_LSB] == CMD_TYPE_UPDATE // [RQ3]
                        && !reg_wdata_i[CMD_AREA_MSB]) // [RQ2]
                    begin
                        s_d.tim_sh[reg_wdata_i[CMD_AREA_LSB+1:CMD_AREA_LSB]] = s_q.cyc_stage; // [RQ1]
                        s_d.mode_sh[reg_wdata_i[CMD_AREA_LSB+1:CMD_AREA_LSB]] = s_q.mode_stage; // [RQ1]
                    end
                end
                OFS_CYCLE_STAGING: s_d.cyc_stage = reg_wdata_i[TIM_W-1:0];
                OFS_MODE_STAGING: s_d.mode_stage = reg_wdata_i[MODE_W-1:0];
                OFS_OPERATION_MODE: s_d.opmode = reg_wdata_i[OPM_W-1:0];
                OFS_BUS_CONTROL: s_d.mux = reg_wdata_i[CTL_MUX_BIT];
                default: s_d.cmd = s_q.cmd;
            endcase
        end

        if (reg_re_i)
        begin
            if (reg_addr_i >= OFS_TIMING_SHADOW0 && reg_addr_i < OFS_MODE_SHADOW0 && reg_addr_i[1:0] == 2'h0)
            begin
                s_d.rdata = {11'h000, s_q.tim_sh[area_of(reg_addr_i, OFS_TIMING_SHADOW0)]};
            end
            else if (reg_addr_i >= OFS_MODE_SHADOW0 && reg_addr_i < OFS_BUS_CONTROL && reg_addr_i[1:0] == 2'h0)
            begin
                s_d.rdata = {16'h0000, s_q.mode_sh[area_of(reg_addr_i, OFS_MODE_SHADOW0)]}; // [RQ21]
            end
            else
            begin
                case (reg_addr_i)
                    OFS_APPLY_COMMAND: s_d.rdata = {6'h00, s_q.cmd, 21'h000000}; // [RQ4]
                    OFS_CYCLE_STAGING: s_d.rdata = {11'h000, s_q.cyc_stage};
                    OFS_MODE_STAGING: s_d.rdata = {16'h0000, s_q.mode_stage};
                    OFS_OPERATION_MODE: s_d.rdata = {27'h0000000, s_q.opmode};
                    OFS_BUS_CONTROL: s_d.rdata = {31'h00000000, s_q.mux};
                    OFS_STATUS: s_d.rdata = {19'h00000, s_q.boundary, s_q.last_wr, s_q.last_area,
                                             (s_q.state != SM_IDLE)};
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end

        unique case (s_q.state)
            SM_IDLE:
            begin
                if (req_valid_i)
                begin
                    s_d.area = req_i.area;
                    s_d.wr = req_i.write;
                    // Shadows are sampled at the start so an update lands on the next access
                    s_d.tim = s_q.tim_sh[req_i.area]; // [RQ22]
                    s_d.wr_sync = s_q.mode_sh[req_i.area][MODE_WR_SYNC_BIT];
                    s_d.boundary = boundary_of(s_q.mode_sh[req_i.area][MODE_BURST_MSB:MODE_BURST_LSB]); // [RQ19]
                    s_d.cnt = 4'h0;
                    s_d.state = need_turn ? SM_TURN : SM_ACCESS;
                end
            end
            SM_TURN:
            begin
                // A zero turnaround still yields one gap cycle
                if ({1'b0, s_q.cnt} + 5'h01 >= {2'h0, tr}) // [RQ6]
                begin
                    s_d.cnt = 4'h0;
                    s_d.state = SM_ACCESS;
                end
                else
                begin
                    s_d.cnt = s_q.cnt + 4'h1;
                end
            end
            SM_ACCESS:
            begin
                if (!mem_wait_i) // [RQ18]
                begin
                    if ({1'b0, s_q.cnt} + 5'h01 >= {1'b0, len}) // [RQ13] [RQ14] [RQ15]
                    begin
                        s_d.state = SM_IDLE;
                        s_d.cnt = 4'h0;
                        s_d.done = 1'b1;
                        s_d.have_last = 1'b1;
                        s_d.last_wr = s_q.wr;
                        s_d.last_area = s_q.area;
                    end
                    else
                    begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                end
            end
        endcase

        // Strobes are derived from the next count so the pins come straight from flops
        s_d.cs = (s_d.state == SM_ACCESS);
        if (s_q.mux && !s_d.wr_sync && !s_d.tim[TIM_WE_TIME_BIT]) // [RQ5]
        begin
            ws_start = WE_LATE_CYCLES;
        end
        ws_end = ws_start + {2'h0, s_d.tim[TIM_WP_MSB:TIM_WP_LSB]}; // [RQ10]
        s_d.ws = s_d.cs && s_d.wr && ({1'b0, s_d.cnt} >= ws_start)
            && (s_q.opmode[OPM_WRITE_HOLD_BIT] || ({1'b0, s_d.cnt} < ws_end)); // [RQ11]
        s_d.rs = s_d.cs && !s_d.wr && ({1'b0, s_d.cnt} >= {2'h0, s_d.tim[TIM_CEOE_MSB:TIM_CEOE_LSB]}); // [RQ12]
        // Page access timing is kept per area; this sequencer issues single accesses only [RQ9]
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '{state: SM_IDLE, default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    assign req_ready_o = (s_q.state == SM_IDLE);
    assign access_done_o = s_q.done;
    assign burst_boundary_o = s_q.boundary;
    assign pins_o.area_select_n = ~({3'h0, s_q.cs} << s_q.area);
    assign pins_o.read_strobe_n = ~s_q.rs;
    assign pins_o.write_strobe_n = ~s_q.ws;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence update_cmd_s;
        reg_we_i && reg_addr_i == OFS_APPLY_COMMAND && reg_wdata_i[22:21] == 2'h2 && !reg_wdata_i[25];
    endsequence

    sequence late_write_start_s;
        $rose(s_q.cs) && s_q.wr && s_q.mux && !s_q.wr_sync && !s_q.tim[20];
    endsequence

    apply_copy_a: assert property (update_cmd_s |=>
        s_q.tim_sh[$past(reg_wdata_i[24:23])] == $past(s_q.cyc_stage)
        && s_q.mode_sh[$past(reg_wdata_i[24:23])] == $past(s_q.mode_stage))
        else $error("shadow not updated by apply command"); // [RQ1]
    bad_area_a: assert property (reg_we_i && reg_addr_i == OFS_APPLY_COMMAND && reg_wdata_i[25]
        |=> $stable(s_q.tim_sh) && $stable(s_q.mode_sh))
        else $error("prohibited area code changed a shadow"); // [RQ2]
    bad_type_a: assert property (reg_we_i && reg_addr_i == OFS_APPLY_COMMAND && reg_wdata_i[22:21] != 2'h2
        |=> $stable(s_q.tim_sh) && $stable(s_q.mode_sh))
        else $error("prohibited command type changed a shadow"); // [RQ3]
    cmd_reserved_a: assert property (reg_re_i && reg_addr_i == OFS_APPLY_COMMAND
        |=> reg_rdata_o[31:26] == 6'h00 && reg_rdata_o[20:0] == 21'h000000)
        else $error("reserved command bits read nonzero"); // [RQ4]
    late_write_a: assert property (late_write_start_s |-> pins_o.write_strobe_n)
        else $error("write strobe not delayed after chip-select"); // [RQ5]
    mux_gap_a: assert property ($fell(s_q.cs) && s_q.mux |=> !s_q.cs)
        else $error("no gap between multiplexed accesses"); // [RQ8]
    cs_length_a: assert property ($fell(s_q.cs) |->
        $past(s_q.cnt) + 4'h1 == ($past(s_q.wr) ? $past(s_q.tim[7:4]) : $past(s_q.tim[3:0])))
        else $error("chip-select length differs from start count"); // [RQ15]
    wait_stretch_a: assert property (s_q.state == SM_ACCESS && mem_wait_i |=> $stable(s_q.cnt) && s_q.cs)
        else $error("access not stretched by wait"); // [RQ18]
    read_delay_a: assert property ($rose(s_q.rs) |-> s_q.cnt == {1'b0, s_q.tim[10:8]} || s_q.tim[10:8] == 3'h0)
        else $error("read strobe delay wrong"); // [RQ12]
    hold_write_a: assert property (s_q.ws && s_q.opmode[1] && s_d.cs |=> s_q.ws)
        else $error("write strobe dropped under write-hold"); // [RQ11]

endmodule
